// [dcwd_avalon_slave.sv]
// Avalon-MM handshake for the decoder registers: one wait state per access.
// Assumes the master holds the request until it sees waitrequest low.
`timescale 1ns/1ps
module dcwd_avalon_slave import dcwd_pkg::*; (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] rd_data_in,
  output logic waitrequest_out,
  output logic [31:0] readdata_out,
  output logic take_out
);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
  } dcwd_slv_t;

  dcwd_slv_t q;
  dcwd_slv_t next_q;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Waitrequest idles high so a new request always sees one wait cycle
  always_comb begin
    next_q = q;
    next_q.waitreq = 1'b1;
    if ((read_in || write_in) && q.waitreq) begin
      next_q.waitreq = 1'b0;
      next_q.rdata = rd_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{waitreq: 1'b1, rdata: DCWD_READ_ZERO};
    end else begin
      q <= next_q;
    end
  end

  assign waitrequest_out = q.waitreq;
  assign readdata_out = q.rdata;
  assign take_out = (read_in || write_in) && !q.waitreq;

endmodule // dcwd_avalon_slave

// [dcwd_decoder.sv]
// Drive command word decoder: register, transition decode, motion decode.
// Assumes drive state, mode indicator and busy flag arrive on core_clk_in.
//
// Contract
// - Combined switch-on plus enable runs step 3, then step 4 by itself.
// - Bits 0-3 and 7 encode state transitions in every mode.
// - Match shutdown x110, switch on 0111, enable 1111, with bit 7 clear.
// - Fault clear only on a low-to-high change of bit 7.
// - Mode bits follow the active mode; elsewhere they are reserved.
// - Profile position: bit 4 rising edge starts the positioning move.
// - Homing: bit 4 set starts homing, cleared stops it.
// - Interpolated position: bit 4 enables interpolation while set.
// - Profile position: bit 5 picks single or set, sampled at strobe.
// - Profile position: bit 6 picks absolute or relative, sampled at strobe.
// - Bit 8 requests a halt in every mode.
// - Gear mode: bit 13 picks the starting ratio of the ramp.
// - Gear mode: bit 14 arms the ramp start.
// - Gear mode: bit 15 starts the geared movement.
// - Changed state bits make the write ignore bits 4-6 and 8-15.
// - Unchanged state bits: other bits act only in operation enabled.
// - While a transition runs, changed command words are refused.
// - A status flag reports when command word changes are refused.
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module dcwd_decoder import dcwd_pkg::*; (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [DCWD_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] active_mode_indicator_in,
  input wire logic switched_on_in,
  input wire logic op_enabled_in,
  input wire logic transition_busy_in,
  output logic cmd_shutdown_out,
  output logic cmd_switch_on_out,
  output logic cmd_enable_op_out,
  output logic cmd_disable_voltage_out,
  output logic cmd_quick_stop_out,
  output logic cmd_fault_reset_out,
  output logic new_setpoint_out,
  output logic set_of_points_out,
  output logic target_interpretation_select_out,
  output logic homing_start_out,
  output logic interpolation_enable_out,
  output logic halt_out,
  output logic gear_ratio_select_out,
  output logic ramp_arm_out,
  output logic gear_start_out,
  output logic cmd_locked_out
);

  typedef struct packed {
    logic [DCWD_CMD_W-1:0] cmd_word;
    logic motion_bit4;
    logic shutdown;
    logic disable_v;
    logic quick_stop;
    logic fault_reset;
    logic setpoint;
    logic set_select;
    logic target_sel;
    logic homing;
    logic interp;
    logic halt;
    logic gear_ratio;
    logic ramp_arm;
    logic gear_start;
    logic locked;
    logic rejected;
    logic last_state;
  } dcwd_dec_t;

  dcwd_dec_t q;
  dcwd_dec_t next_q;

  logic take;
  logic take_wr;
  logic take_rd_status;
  logic [31:0] rd_data;
  logic [DCWD_CMD_W-1:0] merged;
  logic [3:0] nib;
  logic state_changed;
  logic refuse;
  logic accept;
  logic req_switch_on;
  logic req_enable;
  logic abort;
  logic seq_pending;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  dcwd_avalon_slave u_slave (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .read_in(avs_read_in),
    .write_in(avs_write_in),
    .rd_data_in(rd_data),
    .waitrequest_out(avs_waitrequest_out),
    .readdata_out(avs_readdata_out),
    .take_out(take)
  );

  assign take_wr = take && avs_write_in && (avs_address_in == DCWD_OFF_CMD);
  assign take_rd_status = take && avs_read_in && (avs_address_in == DCWD_OFF_STATUS);

  // Only the two low byte lanes carry the command word
  always_comb begin
    merged = q.cmd_word;
    if (avs_byteenable_in[0]) begin
      merged[7:0] = avs_writedata_in[7:0];
    end
    if (avs_byteenable_in[1]) begin
      merged[15:8] = avs_writedata_in[15:8];
    end
  end

  assign nib = merged[3:0];
  assign state_changed = (merged & DCWD_STATE_MASK) != (q.cmd_word & DCWD_STATE_MASK);
  // Rewriting the same word while busy is harmless, so only a change is refused
  assign refuse = transition_busy_in && (merged != q.cmd_word);
  assign accept = take_wr && !refuse;

  always_comb begin
    rd_data = DCWD_READ_ZERO;
    case (avs_address_in)
      DCWD_OFF_CMD: rd_data[DCWD_CMD_W-1:0] = q.cmd_word;
      DCWD_OFF_STATUS: begin
        rd_data[DCWD_ST_LOCKED] = q.locked;
        rd_data[DCWD_ST_OP_EN] = op_enabled_in;
        rd_data[DCWD_ST_REJECTED] = q.rejected;
        rd_data[DCWD_ST_LAST_STATE] = q.last_state;
        rd_data[DCWD_ST_SET_SELECT] = q.set_select;
        rd_data[DCWD_ST_TARGET_SEL] = q.target_sel;
        rd_data[DCWD_ST_SEQ_PEND] = seq_pending;
      end
      DCWD_OFF_MODE: rd_data[7:0] = active_mode_indicator_in;
      default: rd_data = DCWD_READ_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    req_switch_on = 1'b0;
    req_enable = 1'b0;
    abort = 1'b0;
    next_q.shutdown = 1'b0;
    next_q.disable_v = 1'b0;
    next_q.quick_stop = 1'b0;
    next_q.fault_reset = 1'b0;
    next_q.setpoint = 1'b0;
    next_q.locked = transition_busy_in;
    // Clear first so that a refusal in the same cycle still lands
    if (take_rd_status) begin
      next_q.rejected = 1'b0;
    end
    if (take_wr && refuse) begin
      next_q.rejected = 1'b1;
    end
    if (accept) begin
      next_q.cmd_word = merged;
      next_q.last_state = state_changed;
      if (state_changed) begin
        abort = 1'b1;
        // Motion bits of this write are dropped on purpose
        if (merged[DCWD_B_FAULT_RESET] && !q.cmd_word[DCWD_B_FAULT_RESET]) begin
          next_q.fault_reset = 1'b1;
        end else if (!merged[DCWD_B_FAULT_RESET]) begin
          if ((nib & DCWD_DISV_MASK) == DCWD_DISV_VAL) begin
            next_q.disable_v = 1'b1;
          end else if ((nib & DCWD_QSTOP_MASK) == DCWD_QSTOP_VAL) begin
            next_q.quick_stop = 1'b1;
          end else if ((nib & DCWD_SHUT_MASK) == DCWD_SHUT_VAL) begin
            next_q.shutdown = 1'b1;
          end else if ((nib & DCWD_FULL_MASK) == DCWD_SWON_VAL) begin
            req_switch_on = 1'b1;
          end else if ((nib & DCWD_FULL_MASK) == DCWD_ENOP_VAL) begin
            req_enable = 1'b1;
          end
        end
      end else if (op_enabled_in) begin
        next_q.halt = merged[DCWD_B_HALT];
        next_q.motion_bit4 = merged[DCWD_B_SETPOINT];
        case (active_mode_indicator_in)
          DCWD_MODE_PROFILE_POS: begin
            if (merged[DCWD_B_SETPOINT] && !q.motion_bit4) begin
              next_q.setpoint = 1'b1;
              next_q.set_select = merged[DCWD_B_SET_SELECT];
              next_q.target_sel = merged[DCWD_B_TARGET_SEL];
            end
          end
          DCWD_MODE_HOMING: next_q.homing = merged[DCWD_B_SETPOINT];
          DCWD_MODE_INTERP: next_q.interp = merged[DCWD_B_SETPOINT];
          DCWD_MODE_GEAR: begin
            next_q.gear_ratio = merged[DCWD_B_GEAR_RATIO];
            next_q.ramp_arm = merged[DCWD_B_RAMP_ARM];
            next_q.gear_start = merged[DCWD_B_GEAR_START];
          end
          default: begin
          end
        endcase
      end
    end
    // Mode-bound levels drop as soon as their mode is left
    if (active_mode_indicator_in != DCWD_MODE_HOMING) begin
      next_q.homing = 1'b0;
    end
    if (active_mode_indicator_in != DCWD_MODE_INTERP) begin
      next_q.interp = 1'b0;
    end
    if (active_mode_indicator_in != DCWD_MODE_GEAR) begin
      next_q.gear_ratio = 1'b0;
      next_q.ramp_arm = 1'b0;
      next_q.gear_start = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.cmd_word <= DCWD_CMD_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Switch-on / enable sequencing
  // ----------------------------------------------------------------
  dcwd_enable_seq u_seq (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .req_switch_on_in(req_switch_on),
    .req_enable_in(req_enable),
    .abort_in(abort),
    .switched_on_in(switched_on_in),
    .op_enabled_in(op_enabled_in),
    .busy_in(transition_busy_in),
    .switch_on_out(cmd_switch_on_out),
    .enable_op_out(cmd_enable_op_out),
    .pending_out(seq_pending)
  );

  assign cmd_shutdown_out = q.shutdown;
  assign cmd_disable_voltage_out = q.disable_v;
  assign cmd_quick_stop_out = q.quick_stop;
  assign cmd_fault_reset_out = q.fault_reset;
  assign new_setpoint_out = q.setpoint;
  assign set_of_points_out = q.set_select;
  assign target_interpretation_select_out = q.target_sel;
  assign homing_start_out = q.homing;
  assign interpolation_enable_out = q.interp;
  assign halt_out = q.halt;
  assign gear_ratio_select_out = q.gear_ratio;
  assign ramp_arm_out = q.ramp_arm;
  assign gear_start_out = q.gear_start;
  assign cmd_locked_out = q.locked;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcwd_cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_refuse_change;
    take_wr && transition_busy_in && (merged != q.cmd_word)
      |=> (q.cmd_word == $past(q.cmd_word)) && q.rejected && !new_setpoint_out;
  endproperty
  a_refuse_change: assert property (p_refuse_change)
    else $error("changed word taken during a transition");

  property p_locked_flag;
    transition_busy_in |=> cmd_locked_out;
  endproperty
  a_locked_flag: assert property (p_locked_flag)
    else $error("locked flag missing while busy");

  property p_fault_edge;
    cmd_fault_reset_out |-> q.cmd_word[DCWD_B_FAULT_RESET]
      && !$past(q.cmd_word[DCWD_B_FAULT_RESET]) && !$past(cmd_fault_reset_out);
  endproperty
  a_fault_edge: assert property (p_fault_edge)
    else $error("fault clear without a rising bit 7");

  property p_shutdown_code;
    cmd_shutdown_out |-> !q.cmd_word[DCWD_B_FAULT_RESET]
      && ((q.cmd_word[3:0] & DCWD_SHUT_MASK) == DCWD_SHUT_VAL);
  endproperty
  a_shutdown_code: assert property (p_shutdown_code)
    else $error("shutdown decoded from a wrong pattern");

  property p_state_write_ignores_motion;
    accept && state_changed
      |=> !new_setpoint_out && (halt_out == $past(halt_out))
        && (gear_start_out == $past(gear_start_out) || !gear_start_out);
  endproperty
  a_state_write_ignores_motion: assert property (p_state_write_ignores_motion)
    else $error("motion bits acted on in a state write");

  property p_motion_needs_enabled;
    accept && !state_changed && !op_enabled_in |=> (halt_out == $past(halt_out));
  endproperty
  a_motion_needs_enabled: assert property (p_motion_needs_enabled)
    else $error("motion bits acted on outside operation enabled");

  property p_halt_follows;
    accept && !state_changed && op_enabled_in |=> halt_out == $past(merged[DCWD_B_HALT]);
  endproperty
  a_halt_follows: assert property (p_halt_follows)
    else $error("halt did not follow bit 8");

  property p_setpoint_edge;
    new_setpoint_out |-> ($past(active_mode_indicator_in) == DCWD_MODE_PROFILE_POS)
      && q.cmd_word[DCWD_B_SETPOINT] && !$past(q.motion_bit4) ##1 !new_setpoint_out;
  endproperty
  a_setpoint_edge: assert property (p_setpoint_edge)
    else $error("set-point strobe without a bit 4 rising edge");

  property p_setpoint_sample;
    new_setpoint_out |-> (set_of_points_out == q.cmd_word[DCWD_B_SET_SELECT])
      && (target_interpretation_select_out == q.cmd_word[DCWD_B_TARGET_SEL]);
  endproperty
  a_setpoint_sample: assert property (p_setpoint_sample)
    else $error("selectors not sampled with the strobe");

  property p_homing_mode;
    homing_start_out |-> $past(active_mode_indicator_in) == DCWD_MODE_HOMING;
  endproperty
  a_homing_mode: assert property (p_homing_mode)
    else $error("homing start outside homing mode");

  property p_interp_mode;
    interpolation_enable_out |-> $past(active_mode_indicator_in) == DCWD_MODE_INTERP;
  endproperty
  a_interp_mode: assert property (p_interp_mode)
    else $error("interpolation enabled outside its mode");

  property p_gear_mode;
    (gear_start_out || ramp_arm_out || gear_ratio_select_out)
      |-> $past(active_mode_indicator_in) == DCWD_MODE_GEAR;
  endproperty
  a_gear_mode: assert property (p_gear_mode)
    else $error("gear bits active outside gear mode");

endmodule // dcwd_decoder

// [dcwd_drive_model.sv]
// Drive state machine stand-in: answers transition pulses after a delay.
// Assumes one-cycle command pulses on the core clock.
`timescale 1ns/1ps
module dcwd_drive_model #(
  parameter int BUSY_CYC = 6
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic go_on_in,
  input wire logic go_op_in,
  input wire logic go_off_in,
  output logic switched_on_out,
  output logic op_enabled_out,
  output logic busy_out
);
  int cnt;
  logic [1:0] tgt;
  // Busy long enough that a follow-up write lands mid-transition
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 0;
      tgt <= 2'b00;
      busy_out <= 1'b0;
      switched_on_out <= 1'b0;
      op_enabled_out <= 1'b0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        busy_out <= 1'b0;
        {switched_on_out, op_enabled_out} <= tgt;
      end
    end else if (go_on_in || go_op_in || go_off_in) begin
      busy_out <= 1'b1;
      cnt <= BUSY_CYC;
      tgt <= go_op_in ? 2'b11 : (go_on_in ? 2'b10 : 2'b00);
    end
  end
endmodule // dcwd_drive_model

// [dcwd_enable_seq.sv]
// Switch-on / enable-operation sequencer of the command word decoder.
// Assumes drive state flags come from the state machine on the same clock.
`timescale 1ns/1ps
module dcwd_enable_seq import dcwd_pkg::*; (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_switch_on_in,
  input wire logic req_enable_in,
  input wire logic abort_in,
  input wire logic switched_on_in,
  input wire logic op_enabled_in,
  input wire logic busy_in,
  output logic switch_on_out,
  output logic enable_op_out,
  output logic pending_out
);

  typedef struct packed {
    dcwd_seq_t state;
    logic swon;
    logic enop;
  } dcwd_seq_st_t;

  dcwd_seq_st_t q;
  dcwd_seq_st_t next_q;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.swon = 1'b0;
    next_q.enop = 1'b0;
    unique case (q.state)
      DCWD_SEQ_IDLE: begin
      end
      DCWD_SEQ_WAIT: begin
        // Step 4 follows once the switch-on step has settled
        if (switched_on_in && !busy_in) begin
          next_q.enop = 1'b1;
          next_q.state = DCWD_SEQ_IDLE;
        end
      end
    endcase
    if (abort_in) begin
      next_q.state = DCWD_SEQ_IDLE;
      next_q.enop = 1'b0;
    end
    if (req_switch_on_in) begin
      next_q.swon = 1'b1;
    end
    if (req_enable_in && !op_enabled_in) begin
      if (switched_on_in) begin
        next_q.enop = 1'b1;
      end else begin
        next_q.swon = 1'b1;
        next_q.state = DCWD_SEQ_WAIT;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '{state: DCWD_SEQ_IDLE, swon: 1'b0, enop: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign switch_on_out = q.swon;
  assign enable_op_out = q.enop;
  assign pending_out = (q.state == DCWD_SEQ_WAIT);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_combined_step4;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (q.state == DCWD_SEQ_WAIT) && switched_on_in && !busy_in && !abort_in
      |=> enable_op_out ##1 !enable_op_out;
  endproperty
  a_combined_step4: assert property (p_combined_step4)
    else $error("step 4 did not follow switch-on");

  property p_combined_step3;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    req_enable_in && !op_enabled_in && !switched_on_in
      |=> switch_on_out && pending_out;
  endproperty
  a_combined_step3: assert property (p_combined_step3)
    else $error("combined command did not start with switch-on");

endmodule // dcwd_enable_seq

// [dcwd_pkg.sv]
// Shared constants for the drive command word decoder.
// Assumes a single 250 MHz core clock and word-aligned Avalon-MM byte addresses.
package dcwd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int DCWD_ADDR_W = 4;
  localparam logic [3:0] DCWD_OFF_CMD = 4'h0;
  localparam logic [3:0] DCWD_OFF_STATUS = 4'h4;
  localparam logic [3:0] DCWD_OFF_MODE = 4'h8;
  localparam logic [15:0] DCWD_CMD_RESET = 16'h0000;
  localparam logic [31:0] DCWD_READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int DCWD_CMD_W = 16;
  localparam int DCWD_B_SETPOINT = 4;
  localparam int DCWD_B_SET_SELECT = 5;
  localparam int DCWD_B_TARGET_SEL = 6;
  localparam int DCWD_B_FAULT_RESET = 7;
  localparam int DCWD_B_HALT = 8;
  localparam int DCWD_B_GEAR_RATIO = 13;
  localparam int DCWD_B_RAMP_ARM = 14;
  localparam int DCWD_B_GEAR_START = 15;
  localparam logic [15:0] DCWD_STATE_MASK = 16'h008f;

  // Low-nibble patterns: mask and value
  localparam logic [3:0] DCWD_DISV_MASK = 4'h2;
  localparam logic [3:0] DCWD_DISV_VAL = 4'h0;
  localparam logic [3:0] DCWD_QSTOP_MASK = 4'h6;
  localparam logic [3:0] DCWD_QSTOP_VAL = 4'h2;
  localparam logic [3:0] DCWD_SHUT_MASK = 4'h7;
  localparam logic [3:0] DCWD_SHUT_VAL = 4'h6;
  localparam logic [3:0] DCWD_FULL_MASK = 4'hf;
  localparam logic [3:0] DCWD_SWON_VAL = 4'h7;
  localparam logic [3:0] DCWD_ENOP_VAL = 4'hf;

  // ----------------------------------------------------------------
  // Operating mode codes (signed 8-bit indicator)
  // ----------------------------------------------------------------
  localparam logic [7:0] DCWD_MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] DCWD_MODE_HOMING = 8'h06;
  localparam logic [7:0] DCWD_MODE_INTERP = 8'h07;
  localparam logic [7:0] DCWD_MODE_GEAR = 8'h82;

  // ----------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------
  localparam int DCWD_ST_LOCKED = 0;
  localparam int DCWD_ST_OP_EN = 1;
  localparam int DCWD_ST_REJECTED = 2;
  localparam int DCWD_ST_LAST_STATE = 3;
  localparam int DCWD_ST_SET_SELECT = 4;
  localparam int DCWD_ST_TARGET_SEL = 5;
  localparam int DCWD_ST_SEQ_PEND = 6;

  typedef enum logic [1:0] {
    DCWD_SEQ_IDLE = 2'b01,
    DCWD_SEQ_WAIT = 2'b10
  } dcwd_seq_t;

endpackage

// [testbench.sv]
// Self-checking bench for the command word decoder.
// Assumes one wait state per access and the drive model on the far side.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench import dcwd_pkg::*;;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] mode = 8'h00;
  logic [31:0] rdata, q;
  logic wreq, sw_on, op_en, busy, locked;
  wire [6:0] pl;
  wire [7:0] lv;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [15:0] tw [8] = '{16'h6, 16'he, 16'h0, 16'h2, 16'h80, 16'h80, 16'h7, 16'h87};
  logic [6:0] te [8] = '{7'h40, 7'h40, 7'h08, 7'h04, 7'h02, 7'h00, 7'h20, 7'h02};
  logic [7:0] mm [10] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h6, 8'h6, 8'h7, 8'h7, 8'h82, 8'h6};
  logic [15:0] mw [10] = '{16'h7f, 16'h17f, 16'hf, 16'h1f, 16'h1f, 16'hf, 16'h1f, 16'hf,
                           16'he01f, 16'he01f};
  logic [6:0] me [10] = '{7'h1, 7'h0, 7'h0, 7'h1, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0};
  logic [7:0] ml [10] = '{8'hc0, 8'hc8, 8'hc0, 8'h00, 8'h20, 8'h00, 8'h10, 8'h00, 8'h07, 8'h20};

  always #2 core_clk = ~core_clk;

  dcwd_decoder u_dut (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'h3),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .active_mode_indicator_in(mode),
    .switched_on_in(sw_on), .op_enabled_in(op_en), .transition_busy_in(busy),
    .cmd_shutdown_out(pl[6]), .cmd_switch_on_out(pl[5]), .cmd_enable_op_out(pl[4]),
    .cmd_disable_voltage_out(pl[3]), .cmd_quick_stop_out(pl[2]), .cmd_fault_reset_out(pl[1]),
    .new_setpoint_out(pl[0]), .set_of_points_out(lv[7]),
    .target_interpretation_select_out(lv[6]), .homing_start_out(lv[5]),
    .interpolation_enable_out(lv[4]), .halt_out(lv[3]), .gear_ratio_select_out(lv[2]),
    .ramp_arm_out(lv[1]), .gear_start_out(lv[0]), .cmd_locked_out(locked));

  dcwd_drive_model u_drive (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .go_on_in(pl[5]),
    .go_op_in(pl[4]), .go_off_in(|{pl[6], pl[3:1]}), .switched_on_out(sw_on),
    .op_enabled_out(op_en), .busy_out(busy));

  // ----
  // Bus access and checks
  // ----
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    // Request stands until the rising edge that samples waitrequest low
    do begin
      @(posedge core_clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    q = rdata;
    `CHK("waitrequest", 1'b0, wreq)
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrc(input logic [15:0] d, input logic [6:0] ep, input logic [7:0] el);
    bus(1'b1, DCWD_OFF_CMD, {16'h0, d});
    @(negedge core_clk);
    `CHK("pulses", ep, pl)
    `CHK("levels", el, lv)
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("readdata", e, q)
    @(posedge core_clk);
  endtask

  // Waits out the drive model's transition
  task automatic settle();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((busy !== 1'b0 || k < 3) && k < 40);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rdc(DCWD_OFF_CMD, 32'h0);
    rdc(DCWD_OFF_STATUS, 32'h0);
    rdc(4'hc, 32'h0);
    mode <= 8'h06;
    rdc(DCWD_OFF_MODE, 32'h6);
    $display("test reset done");
    foreach (tw[i]) begin
      wrc(tw[i], te[i], 8'h00);
      settle();
    end
    $display("test transitions done");
    wrc(16'hf, 7'h20, 8'h00);
    n = 0;
    while (pl !== 7'h10 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("auto enable", 7'h10, pl)
    settle();
    rdc(DCWD_OFF_STATUS, 32'ha);
    $display("test combined enable done");
    for (int i = 0; i < 4; i++) begin
      mode <= mm[i];
      wrc(mw[i], me[i], ml[i]);
    end
    for (int i = 4; i < 10; i++) begin
      mode <= mm[i];
      wrc(mw[i], me[i], ml[i]);
    end
    $display("test motion bits done");
    mode <= 8'h01;
    wrc(16'h107, 7'h20, 8'h00);
    settle();
    wrc(16'h117, 7'h00, 8'h00);
    $display("test gating done");
    wrc(16'h6, 7'h40, 8'h00);
    wrc(16'h7, 7'h00, 8'h00);
    @(negedge core_clk);
    `CHK("locked", 1'b1, locked)
    settle();
    rdc(DCWD_OFF_STATUS, 32'hc);
    rdc(DCWD_OFF_CMD, 32'h6);
    rdc(DCWD_OFF_STATUS, 32'h8);
    $display("test refusal done");
    end_sim();
  end
endmodule // testbench
